//--- core/wdpc_pkg.sv
// Overview of operation
// - expiry resets CPU or raises interrupt
// - interval values 01h to 3Fh only
// - one interval count equals one second, or one minute when index F5h is not 00h
// - rewriting interval port restarts the timeout
// - reading interval port disables the watchdog
// - write 87h twice to 2Eh enters configuration
// - index at 2Eh, value at 2Fh
// - index 07h selects logical device number
// - index 30h activates (01h) or deactivates (00h)
// - index F5h value 00h counts seconds
// - index F6h holds timeout count
// - writing AAh to 2Eh leaves configuration
package wdpc_pkg;

	// i/o port addresses
	localparam logic [15:0] IO_INTERVAL_PORT = 16'h0440;
	localparam logic [15:0] IO_CFG_INDEX     = 16'h002E;
	localparam logic [15:0] IO_CFG_DATA      = 16'h002F;

	// configuration register indices
	localparam logic [7:0] IDX_LDN      = 8'h07;
	localparam logic [7:0] IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] IDX_UNIT     = 8'hF5;
	localparam logic [7:0] IDX_COUNT    = 8'hF6;

	// key bytes and fixed values
	localparam logic [7:0] KEY_ENTER    = 8'h87;
	localparam logic [7:0] KEY_EXIT     = 8'hAA;
	localparam logic [7:0] LDN_WDT      = 8'h08;
	localparam logic [7:0] INTERVAL_MIN = 8'h01;
	localparam logic [7:0] INTERVAL_MAX = 8'h3F;
	localparam logic [7:0] UNIT_SECONDS = 8'h00;
	localparam logic [7:0] FLOAT_READ   = 8'hFF;

	// reset values
	localparam logic [7:0] RST_LDN   = 8'h00;
	localparam logic [7:0] RST_INDEX = 8'h00;
	localparam logic [7:0] RST_UNIT  = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;

	// timing: a second in milliseconds and clock rate
	localparam longint unsigned CLK_HZ    = 64'd25000000;
	localparam longint unsigned SECOND_MS = 64'd1000;
	localparam int unsigned SEC_TICK_CYCLES = int'(CLK_HZ * SECOND_MS / 64'd1000);
	localparam logic [5:0] SECONDS_PER_MIN = 6'h3C;
	localparam logic [4:0] RESET_PULSE_CYCLES = 5'h10;

	// configuration access state
	typedef enum logic [1:0] {
		WDPC_LOCKED = 2'b00,
		WDPC_KEY1   = 2'b01,
		WDPC_CONFIG = 2'b10
	} wdpc_cfg_e;

	// one host i/o cycle
	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic [7:0]  wdata;
	} wdpc_io_req_s;

endpackage

//--- core/wdpc_top.sv
module wdpc_top #(
	parameter int unsigned TICK_CYCLES = wdpc_pkg::SEC_TICK_CYCLES,
	parameter bit          IRQ_MODE    = 1'b0
) (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	// host i/o port cycle, same clock domain
	input  wire wdpc_pkg::wdpc_io_req_s io_req,
	output logic [7:0]                 io_rdata_r,
	// watchdog action
	output logic                       wdt_reset_r,
	output logic                       wdt_irq_r
);

	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	wdpc_pkg::wdpc_cfg_e cfg_r;   // key / configuration state
	logic [7:0]  index_r;         // selected configuration index
	logic [7:0]  ldn_r;           // logical device number
	logic        active_r;        // activate register bit
	logic [7:0]  unit_r;          // counter unit select
	logic [7:0]  count_reg_r;     // programmed timeout count
	logic [7:0]  cnt_r;           // live remaining count
	logic        run_r;           // timer counting
	logic        fire_r;          // one-cycle expiry pulse
	logic [TW-1:0] tick_cnt_r;    // second prescaler
	logic        sec_tick;        // one pulse per second
	logic [5:0]  min_cnt_r;       // seconds within a minute
	logic        unit_tick;       // one pulse per counting unit
	logic [4:0]  rst_len_r;       // reset pulse stretcher

	// decoded strobes
	logic wr_int, rd_int, wr_idx, wr_dat, rd_dat, in_cfg, wdt_sel;
	logic int_ok, load_int, act_wr, cnt_wr;

	assign wr_int  = io_req.wr && io_req.addr == wdpc_pkg::IO_INTERVAL_PORT;
	assign rd_int  = io_req.rd && io_req.addr == wdpc_pkg::IO_INTERVAL_PORT;
	assign in_cfg  = cfg_r == wdpc_pkg::WDPC_CONFIG;
	assign wr_idx  = io_req.wr && io_req.addr == wdpc_pkg::IO_CFG_INDEX;
	assign wr_dat  = in_cfg && io_req.wr && io_req.addr == wdpc_pkg::IO_CFG_DATA;
	assign rd_dat  = in_cfg && io_req.rd && io_req.addr == wdpc_pkg::IO_CFG_DATA;
	assign wdt_sel = ldn_r == wdpc_pkg::LDN_WDT;
	// out-of-range interval values are dropped, not clamped
	assign int_ok  = io_req.wdata >= wdpc_pkg::INTERVAL_MIN
		&& io_req.wdata <= wdpc_pkg::INTERVAL_MAX;
	assign load_int = wr_int && int_ok;
	assign act_wr  = wr_dat && wdt_sel && index_r == wdpc_pkg::IDX_ACTIVATE;
	assign cnt_wr  = wr_dat && wdt_sel && index_r == wdpc_pkg::IDX_COUNT;

	// key sequence: two 87h in a row unlock, AAh relocks
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cfg_r   <= wdpc_pkg::WDPC_LOCKED;
			index_r <= wdpc_pkg::RST_INDEX;
		end else if (wr_idx) begin
			case (cfg_r)
				wdpc_pkg::WDPC_LOCKED: begin
					if (io_req.wdata == wdpc_pkg::KEY_ENTER)
						cfg_r <= wdpc_pkg::WDPC_KEY1;
				end
				wdpc_pkg::WDPC_KEY1: begin
					// any other byte breaks the sequence
					if (io_req.wdata == wdpc_pkg::KEY_ENTER)
						cfg_r <= wdpc_pkg::WDPC_CONFIG;
					else
						cfg_r <= wdpc_pkg::WDPC_LOCKED;
				end
				wdpc_pkg::WDPC_CONFIG: begin
					if (io_req.wdata == wdpc_pkg::KEY_EXIT)
						cfg_r <= wdpc_pkg::WDPC_LOCKED;
					else
						index_r <= io_req.wdata;
				end
				default: cfg_r <= wdpc_pkg::WDPC_LOCKED;
			endcase
		end
	end

	// configuration registers behind the data port
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ldn_r       <= wdpc_pkg::RST_LDN;
			unit_r      <= wdpc_pkg::RST_UNIT;
			count_reg_r <= wdpc_pkg::RST_COUNT;
		end else if (wr_dat) begin
			if (index_r == wdpc_pkg::IDX_LDN)
				ldn_r <= io_req.wdata;
			else if (wdt_sel && index_r == wdpc_pkg::IDX_UNIT)
				unit_r <= io_req.wdata;
			else if (cnt_wr)
				count_reg_r <= io_req.wdata;
		end
	end

	// read data: live count on the interval port, registers on the data port
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			io_rdata_r <= wdpc_pkg::FLOAT_READ;
		end else if (rd_int) begin
			io_rdata_r <= cnt_r;
		end else if (rd_dat) begin
			if (index_r == wdpc_pkg::IDX_LDN)
				io_rdata_r <= ldn_r;
			else if (wdt_sel && index_r == wdpc_pkg::IDX_ACTIVATE)
				io_rdata_r <= {7'h00, active_r};
			else if (wdt_sel && index_r == wdpc_pkg::IDX_UNIT)
				io_rdata_r <= unit_r;
			else if (wdt_sel && index_r == wdpc_pkg::IDX_COUNT)
				io_rdata_r <= count_reg_r;
			else
				io_rdata_r <= wdpc_pkg::FLOAT_READ;
		end else if (io_req.rd) begin
			// unmapped ports read as a floating bus
			io_rdata_r <= wdpc_pkg::FLOAT_READ;
		end
	end

	// second prescaler, restarted on every reload so a refresh gets a full second
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			tick_cnt_r <= '0;
		else if (load_int || act_wr || cnt_wr || !run_r)
			tick_cnt_r <= '0;
		else if (tick_cnt_r == TICK_LAST)
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick_cnt_r + TW'(1);
	end
	assign sec_tick = run_r && tick_cnt_r == TICK_LAST;

	// minute divider, used when the unit register is not seconds
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			min_cnt_r <= '0;
		else if (load_int || act_wr || cnt_wr || !run_r)
			min_cnt_r <= '0;
		else if (sec_tick)
			min_cnt_r <= (min_cnt_r == wdpc_pkg::SECONDS_PER_MIN - 6'h01) ? 6'h00
				: min_cnt_r + 6'h01;
	end
	assign unit_tick = (unit_r == wdpc_pkg::UNIT_SECONDS) ? sec_tick
		: sec_tick && min_cnt_r == wdpc_pkg::SECONDS_PER_MIN - 6'h01;

	// countdown; the interval port overrides the activate path
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cnt_r    <= 8'h00;
			run_r    <= 1'b0;
			active_r <= 1'b0;
			fire_r   <= 1'b0;
		end else begin
			fire_r <= 1'b0;
			if (rd_int) begin
				run_r    <= 1'b0;
				active_r <= 1'b0;
			end else if (load_int) begin
				cnt_r <= io_req.wdata;
				run_r <= 1'b1;
			end else if (act_wr) begin
				active_r <= io_req.wdata[0];
				cnt_r    <= count_reg_r;
				run_r    <= io_req.wdata[0] && count_reg_r != 8'h00;
			end else if (cnt_wr && active_r) begin
				// a zero count stops rather than firing at once
				cnt_r <= io_req.wdata;
				run_r <= io_req.wdata != 8'h00;
			end else if (unit_tick) begin
				cnt_r <= cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					run_r  <= 1'b0;
					fire_r <= 1'b1;
				end
			end
		end
	end

	// expiry action: stretched reset pulse or interrupt held until serviced
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rst_len_r   <= 5'h00;
			wdt_reset_r <= 1'b0;
			wdt_irq_r   <= 1'b0;
		end else begin
			if (fire_r && !IRQ_MODE) begin
				rst_len_r   <= wdpc_pkg::RESET_PULSE_CYCLES - 5'h01;
				wdt_reset_r <= 1'b1;
			end else if (rst_len_r != 5'h00) begin
				rst_len_r <= rst_len_r - 5'h01;
			end else begin
				wdt_reset_r <= 1'b0;
			end
			// set wins over a service access in the same cycle
			if (fire_r && IRQ_MODE)
				wdt_irq_r <= 1'b1;
			else if (load_int || rd_int || act_wr)
				wdt_irq_r <= 1'b0;
		end
	end

	// checks
	a_fire_at_zero: assert property (@(posedge core_clk) disable iff (reset)
		unit_tick && cnt_r == 8'h01 && !io_req.wr && !io_req.rd |=> fire_r && !run_r)
		else $error("expiry did not fire at zero");
	a_reset_stretch: assert property (@(posedge core_clk) disable iff (reset)
		fire_r && !IRQ_MODE |=> wdt_reset_r [*8])
		else $error("reset pulse too short");
	a_interval_load: assert property (@(posedge core_clk) disable iff (reset)
		load_int && !rd_int |=> run_r && cnt_r == $past(io_req.wdata))
		else $error("interval write did not reload");
	a_read_disable: assert property (@(posedge core_clk) disable iff (reset)
		rd_int |=> !run_r ##1 !fire_r)
		else $error("interval read did not disable");
	// an out-of-range write leaves the timer as it was, apart from a normal step
	a_bad_interval: assert property (@(posedge core_clk) disable iff (reset)
		wr_int && !int_ok |=> run_r == $past(run_r) && cnt_r == $past(cnt_r)
		|| $past(unit_tick))
		else $error("invalid interval changed the timer");
	// second key in a row unlocks, other ports may come between the two
	a_key_enter: assert property (@(posedge core_clk) disable iff (reset)
		cfg_r == wdpc_pkg::WDPC_KEY1 && wr_idx
		&& io_req.wdata == wdpc_pkg::KEY_ENTER |=> in_cfg)
		else $error("double key did not unlock");
	// a single key never reaches configuration mode
	a_key_single: assert property (@(posedge core_clk) disable iff (reset)
		cfg_r == wdpc_pkg::WDPC_LOCKED |=> !in_cfg)
		else $error("single key unlocked");
	// expiry drives the interrupt output exactly when the mode parameter selects it
	a_irq_action: assert property (@(posedge core_clk) disable iff (reset)
		fire_r |=> wdt_irq_r == IRQ_MODE)
		else $error("interrupt action wrong for mode");
	a_key_exit: assert property (@(posedge core_clk) disable iff (reset)
		in_cfg && wr_idx && io_req.wdata == wdpc_pkg::KEY_EXIT |=> !in_cfg ##1 !wr_dat)
		else $error("exit key did not lock");
	a_locked_data: assert property (@(posedge core_clk) disable iff (reset)
		!in_cfg |=> $stable(ldn_r) && $stable(count_reg_r))
		else $error("data port decoded while locked");
	a_ldn_write: assert property (@(posedge core_clk) disable iff (reset)
		wr_dat && index_r == wdpc_pkg::IDX_LDN |=> ldn_r == $past(io_req.wdata))
		else $error("device number not written");
	a_deactivate: assert property (@(posedge core_clk) disable iff (reset)
		act_wr && io_req.wdata == 8'h00 |=> !run_r && !active_r)
		else $error("deactivate left timer running");
	a_second_step: assert property (@(posedge core_clk) disable iff (reset)
		sec_tick && unit_r == wdpc_pkg::UNIT_SECONDS && cnt_r > 8'h01
		&& !io_req.wr && !io_req.rd |=> cnt_r == $past(cnt_r) - 8'h01)
		else $error("second unit did not count");
	a_count_load: assert property (@(posedge core_clk) disable iff (reset)
		cnt_wr && active_r && !act_wr |=> cnt_r == $past(io_req.wdata)
		&& count_reg_r == $past(io_req.wdata))
		else $error("count register not loaded");

endmodule

//--- tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// short second keeps the run small
	localparam int T = 10;
	logic                   core_clk;
	logic                   reset;
	wdpc_pkg::wdpc_io_req_s io_req;
	logic [7:0]             io_rdata_r;
	logic                   wdt_reset_r;
	logic                   wdt_irq_r;
	int                     fails, cmp_count, cyc, fires, hi_len, n;
	logic                   rd_d, rst_d;
	logic [7:0]             rq[$]; // expected read data
	int                     fq[$]; // expected fire cycles

	wdpc_top #(.TICK_CYCLES(T), .IRQ_MODE(1'b0)) wdpc_top_i (.core_clk(core_clk),
		.reset(reset), .io_req(io_req), .io_rdata_r(io_rdata_r),
		.wdt_reset_r(wdt_reset_r), .wdt_irq_r(wdt_irq_r));
	wdpc_host wdpc_host_i (.core_clk(core_clk), .io_req(io_req));

	// clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// arm: fire expected n seconds plus pipeline edges after the write
	task automatic arm(input int s);
		wdpc_host_i.wr(wdpc_pkg::IO_INTERVAL_PORT, 8'(s));
		fq.push_back(cyc + s * T + 2);
	endtask

	task automatic rd_exp(input logic [15:0] a, input logic [7:0] e);
		rq.push_back(e);
		wdpc_host_i.rd(a);
	endtask

	// bounded wait for a given number of fires
	task automatic wait_fires(input int k);
		for (int i = 0; i < 100 * T && fires < k; i++) @(posedge core_clk);
		repeat (20) @(posedge core_clk);
		check("fires", fires, k);
	endtask

	// monitor: takes the oldest note whenever a result shows
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		rd_d <= io_req.rd;
		rst_d <= wdt_reset_r;
		if (rd_d) check("rdata", io_rdata_r, rq.size() ? rq.pop_front() : 8'hXX);
		if (wdt_reset_r && !rst_d) begin
			fires++;
			hi_len = 1;
			check("fire_cycle", cyc, fq.size() ? fq.pop_front() : -1);
		end else if (wdt_reset_r) hi_len++;
		if (!wdt_reset_r && rst_d) check("pulse_len", hi_len, 16);
		// reset mode: the interrupt output must never move
		if (wdt_irq_r !== 1'b0) check("irq", wdt_irq_r, 1'b0);
	end

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		$display("Error timeout expected finish seen hang");
		wrap_up();
	end

	initial begin
		reset = 1'b1;
		void'($urandom(48));
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		rd_exp(16'h0441, 8'hFF);
		$display("test unmapped done");
		n = 1 + $urandom % 3;
		arm(n);
		wait_fires(1);
		$display("test interval done");
		arm(3);
		repeat (2 * T) @(posedge core_clk);
		fq.delete();
		wdpc_host_i.wr(wdpc_pkg::IO_INTERVAL_PORT, 8'h40);
		wdpc_host_i.wr(wdpc_pkg::IO_INTERVAL_PORT, 8'h00);
		arm(2);
		wait_fires(2);
		$display("test refresh done");
		arm(5);
		fq.delete();
		repeat (22) @(posedge core_clk);
		rd_exp(wdpc_pkg::IO_INTERVAL_PORT, 8'h03);
		repeat (8 * T) @(posedge core_clk);
		check("fires", fires, 2);
		$display("test disable done");
		wdpc_host_i.unlock();
		wdpc_host_i.cfg(wdpc_pkg::IDX_LDN, wdpc_pkg::LDN_WDT);
		wdpc_host_i.cfg(wdpc_pkg::IDX_UNIT, wdpc_pkg::UNIT_SECONDS);
		wdpc_host_i.cfg(wdpc_pkg::IDX_COUNT, 8'h02);
		wdpc_host_i.cfg(wdpc_pkg::IDX_ACTIVATE, 8'h01);
		fq.push_back(cyc + 2 * T + 2);
		wdpc_host_i.wr(wdpc_pkg::IO_CFG_INDEX, wdpc_pkg::IDX_COUNT);
		rd_exp(wdpc_pkg::IO_CFG_DATA, 8'h02);
		wdpc_host_i.lock();
		wdpc_host_i.cfg(wdpc_pkg::IDX_ACTIVATE, 8'h00);
		wait_fires(3);
		$display("test config done");
		wdpc_host_i.unlock();
		wdpc_host_i.cfg(wdpc_pkg::IDX_LDN, wdpc_pkg::LDN_WDT);
		wdpc_host_i.cfg(wdpc_pkg::IDX_COUNT, 8'h03);
		wdpc_host_i.cfg(wdpc_pkg::IDX_ACTIVATE, 8'h01);
		wdpc_host_i.cfg(wdpc_pkg::IDX_ACTIVATE, 8'h00);
		rd_exp(wdpc_pkg::IO_CFG_DATA, 8'h00);
		wdpc_host_i.cfg(wdpc_pkg::IDX_LDN, 8'h01);
		wdpc_host_i.wr(wdpc_pkg::IO_CFG_INDEX, wdpc_pkg::IDX_ACTIVATE);
		rd_exp(wdpc_pkg::IO_CFG_DATA, 8'hFF);
		wdpc_host_i.lock();
		repeat (5 * T) @(posedge core_clk);
		check("fires", fires, 3);
		$display("test deactivate done");
		// minute unit: one count lasts sixty seconds
		wdpc_host_i.unlock();
		wdpc_host_i.cfg(wdpc_pkg::IDX_LDN, wdpc_pkg::LDN_WDT);
		wdpc_host_i.cfg(wdpc_pkg::IDX_UNIT, 8'h01);
		wdpc_host_i.cfg(wdpc_pkg::IDX_COUNT, 8'h01);
		wdpc_host_i.cfg(wdpc_pkg::IDX_ACTIVATE, 8'h01);
		fq.push_back(cyc + int'(wdpc_pkg::SECONDS_PER_MIN) * T + 2);
		wdpc_host_i.lock();
		wait_fires(4);
		check("left", rq.size() + fq.size(), 0);
		$display("test minutes done");
		wrap_up();
	end
endmodule

//--- tb/wdpc_host.sv
// host software model: issues i/o port cycles, one strobe cycle each
module wdpc_host (
	// clock
	input  wire logic                  core_clk,
	// i/o cycle towards the device
	output wdpc_pkg::wdpc_io_req_s     io_req
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus from time zero
	initial begin
		io_req = '0;
	end

	// port write: strobe high for exactly one sampling edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge core_clk);
		io_req.wr <= 1'b0;
	endtask

	// port read: data is picked up by the bench monitor
	task automatic rd(input logic [15:0] a);
		@(posedge core_clk);
		io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge core_clk);
		io_req.rd <= 1'b0;
	endtask

	// key written twice, nothing else to the index port between
	task automatic unlock();
		wr(wdpc_pkg::IO_CFG_INDEX, wdpc_pkg::KEY_ENTER);
		wr(wdpc_pkg::IO_CFG_INDEX, wdpc_pkg::KEY_ENTER);
	endtask

	// index first, then the value through the data port
	task automatic cfg(input logic [7:0] i, input logic [7:0] v);
		wr(wdpc_pkg::IO_CFG_INDEX, i);
		wr(wdpc_pkg::IO_CFG_DATA, v);
	endtask

	// leave configuration mode
	task automatic lock();
		wr(wdpc_pkg::IO_CFG_INDEX, wdpc_pkg::KEY_EXIT);
	endtask
endmodule
